// *** hdl/hras_pkg.sv ***
// Constants for the receive address recognition and frame status block.
// Assumes a 32-bit APB slave with one register per aligned word.
package hras_pkg;
  // ==========================================================
  // Register indices, byte address is four times the index
  // ==========================================================
  localparam logic [7:0] IDX_RX_COUNT_LOW   = 8'h25;
  localparam logic [7:0] IDX_FIRST_SP       = 8'h26;
  localparam logic [7:0] IDX_RX_STATUS      = 8'h27;
  localparam logic [7:0] IDX_FIRST_EP       = 8'h28;
  localparam logic [7:0] IDX_RX_CTRL        = 8'h29;
  localparam logic [7:0] IDX_RX_COUNT_HIGH  = 8'h2A;
  localparam logic [7:0] IDX_LINK_STATUS2   = 8'h2B;
  localparam logic [7:0] IDX_SECOND_SP      = 8'h2C;
  localparam logic [7:0] IDX_SECOND_EP      = 8'h2D;
  localparam logic [7:0] IDX_MODE           = 8'h2E;
  localparam logic [7:0] IDX_COMMAND        = 8'h2F;
  // ==========================================================
  // Field positions
  // ==========================================================
  localparam int         CMD_ACK_BIT        = 0;
  localparam int         MODE_ADDR2_BIT     = 3;
  localparam int         SP_CRI_BIT         = 1;
  localparam int         SP_MOD_SEL_BIT     = 1;
  localparam int         LS2_MULTIFRAME_BIT = 2;
  localparam int         CR_BIT             = 1;
  // ==========================================================
  // Message transfer modes, held in mode register bits 2..0
  // ==========================================================
  localparam logic [2:0] MODE_AUTO          = 3'h0;
  localparam logic [2:0] MODE_NONAUTO       = 3'h1;
  localparam logic [2:0] MODE_TRANSP1       = 3'h2;
  localparam logic [2:0] MODE_TRANSP2       = 3'h3;
  localparam logic [2:0] MODE_TRANSP3       = 3'h4;
  // ==========================================================
  // Fixed group values and match codes
  // ==========================================================
  localparam logic [5:0] GROUP_SERVICE_PT   = 6'h3F;
  localparam logic [7:0] GROUP_ENDPOINT_ID  = 8'hFF;
  localparam logic [1:0] SPC_SECOND         = 2'h0;
  localparam logic [1:0] SPC_GROUP          = 2'h1;
  localparam logic [1:0] SPC_FIRST          = 2'h2;
  localparam logic [1:0] CTRL_U_TYPE        = 2'h3;
  localparam logic [1:0] CTRL_S_TYPE        = 2'h1;
  localparam logic [11:0] COUNT_MAX         = 12'hFFF;
  localparam logic [3:0] POS_MAX            = 4'hF;
endpackage : hras_pkg

// *** hdl/hras_top.sv ***
// Receive address recognition, control field capture and frame status.
// Assumes an APB master, a deserialiser giving whole bytes and frame ends,
// a receive queue that always accepts, and a transmitter reporting events.
//
// Local design decision: the APB slave port.
`timescale 1ns/1ps
module hras_top #(
  parameter int         AW           = 10,
  parameter logic [1:0] CHIP_VERSION = 2'h0  // Arbitrary value
) (
  input  wire logic          i_mclk,
  input  wire logic          i_sys_rst,
  input  wire logic          i_psel,
  input  wire logic          i_penable,
  input  wire logic          i_pwrite,
  input  wire logic [AW-1:0] i_paddr,
  input  wire logic [31:0]   i_pwdata,
  input  wire logic [3:0]    i_pstrb,
  output logic               o_pready,
  output logic               o_pslverr,
  output logic      [31:0]   o_prdata,
  input  wire logic          i_rx_byte_valid,
  input  wire logic [7:0]    i_rx_byte,
  input  wire logic          i_rx_frame_end,
  input  wire logic          i_rx_crc_ok,
  input  wire logic          i_rx_aborted,
  output logic               o_queue_valid,
  output logic      [7:0]    o_queue_data,
  output logic               o_message_end,
  output logic               o_sframe_rx,
  output logic               o_auto_numbered,
  input  wire logic          i_tx_cmd,
  input  wire logic          i_tx_done,
  input  wire logic          i_sframe_tx_start,
  input  wire logic          i_sframe_tx_done
);
  // ==========================================================
  // Register bus decode
  // ==========================================================
  logic [7:0] first_sp;
  logic [7:0] second_sp;
  logic [7:0] first_ep;
  logic [7:0] second_ep;
  logic [3:0] mode_reg;
  logic       multiframe_disable;
  logic [7:0] st_status;
  logic [7:0] st_ctrl;
  logic [11:0] st_count;
  logic       st_length_overflow;
  logic       hold;
  logic       busy_cmd;
  logic       busy_sf;
  logic [7:0] idx;
  logic       mapped;
  logic       wr_acc;
  logic       ack_cmd;
  logic [7:0] next_rd;

  assign idx = i_paddr[9:2];
  assign mapped = (i_paddr[1:0] == 2'h0) && (idx >= hras_pkg::IDX_RX_COUNT_LOW)
                  && (idx <= hras_pkg::IDX_COMMAND);
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel && i_penable && !mapped;
  assign wr_acc = i_psel && i_penable && i_pwrite && mapped && i_pstrb[0];
  assign ack_cmd = wr_acc && (idx == hras_pkg::IDX_COMMAND)
                   && i_pwdata[hras_pkg::CMD_ACK_BIT];

  always_comb begin
    case (idx)
      hras_pkg::IDX_RX_COUNT_LOW:  next_rd = st_count[7:0];
      hras_pkg::IDX_RX_STATUS:     next_rd = st_status;
      hras_pkg::IDX_RX_CTRL:       next_rd = st_ctrl;
      hras_pkg::IDX_RX_COUNT_HIGH: next_rd = {busy_cmd | busy_sf, CHIP_VERSION,
                                              st_length_overflow, st_count[11:8]};
      hras_pkg::IDX_LINK_STATUS2:  next_rd = {5'h00, multiframe_disable, 2'h0};
      default:                     next_rd = 8'h00;
    endcase
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_prdata <= 32'h0000_0000;
    end else if (i_psel && !i_penable && !i_pwrite) begin
      o_prdata <= {24'h000000, next_rd};
    end
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      first_sp  <= 8'h00;
      second_sp <= 8'h00;
      first_ep  <= 8'h00;
      second_ep <= 8'h00;
      mode_reg  <= 4'h0;
      multiframe_disable <= 1'b0;
    end else if (wr_acc) begin
      case (idx)
        hras_pkg::IDX_FIRST_SP:     first_sp  <= i_pwdata[7:0];
        hras_pkg::IDX_SECOND_SP:    second_sp <= i_pwdata[7:0];
        hras_pkg::IDX_FIRST_EP:     first_ep  <= i_pwdata[7:0];
        hras_pkg::IDX_SECOND_EP:    second_ep <= i_pwdata[7:0];
        hras_pkg::IDX_MODE:         mode_reg  <= i_pwdata[3:0];
        hras_pkg::IDX_LINK_STATUS2: multiframe_disable <= i_pwdata[hras_pkg::LS2_MULTIFRAME_BIT];
        default:                    multiframe_disable <= multiframe_disable;
      endcase
    end
  end

  // ==========================================================
  // Mode decode
  // ==========================================================
  logic       m_auto;
  logic       m_nonauto;
  logic       m_tr1;
  logic       m_tr2;
  logic       m_tr3;
  logic       addr2;
  logic       mod128;

  assign m_auto    = mode_reg[2:0] == hras_pkg::MODE_AUTO;
  assign m_tr1     = mode_reg[2:0] == hras_pkg::MODE_TRANSP1;
  assign m_tr2     = mode_reg[2:0] == hras_pkg::MODE_TRANSP2;
  assign m_tr3     = mode_reg[2:0] == hras_pkg::MODE_TRANSP3;
  assign m_nonauto = !(m_auto || m_tr1 || m_tr2 || m_tr3);
  assign addr2     = mode_reg[hras_pkg::MODE_ADDR2_BIT] || m_tr1;
  assign mod128    = m_auto && second_sp[hras_pkg::SP_MOD_SEL_BIT];

  // ==========================================================
  // Frame header capture
  // ==========================================================
  logic [3:0] pos;
  logic [3:0] cur;
  logic [7:0] byte1;
  logic [7:0] byte2;
  logic [7:0] ctl1;
  logic [7:0] ctl2;
  logic [3:0] ctl_pos;
  logic [3:0] data_pos;
  logic       ctl_two;
  logic       is_s;
  logic       is_u;

  assign cur = (pos == hras_pkg::POS_MAX) ? pos : pos + 4'h1;
  assign ctl_pos = m_tr1 ? 4'h3 : (addr2 ? 4'h3 : 4'h2);
  assign is_u = ctl1[1:0] == hras_pkg::CTRL_U_TYPE;
  assign is_s = ctl1[1:0] == hras_pkg::CTRL_S_TYPE;
  assign ctl_two = mod128 && !is_u;
  always_comb begin
    if (m_tr2)
      data_pos = 4'h1;
    else if (m_tr3)
      data_pos = 4'h2;
    else
      data_pos = ctl_pos + (ctl_two ? 4'h2 : 4'h1);
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pos   <= 4'h0;
      byte1 <= 8'h00;
      byte2 <= 8'h00;
      ctl1  <= 8'h00;
      ctl2  <= 8'h00;
    end else if (i_rx_frame_end) begin
      pos <= 4'h0;
    end else if (i_rx_byte_valid) begin
      pos <= cur;
      if (cur == 4'h1)
        byte1 <= i_rx_byte;
      if (cur == 4'h2)
        byte2 <= i_rx_byte;
      if (!m_tr2 && !m_tr3 && cur == ctl_pos)
        ctl1 <= i_rx_byte;
      if (!m_tr2 && !m_tr3 && cur == ctl_pos + 4'h1)
        ctl2 <= i_rx_byte;
    end
  end

  // ==========================================================
  // Address comparison
  // ==========================================================
  logic [7:0] ep_byte;
  logic       sp1_hit;
  logic       sp2_hit;
  logic       spg_hit;
  logic       ep1_hit;
  logic       ep2_hit;
  logic       epg_hit;
  logic       addr_ok;
  logic [1:0] spc;
  logic       epf;

  assign ep_byte = addr2 ? byte2 : byte1;
  assign sp1_hit = byte1[7:2] == first_sp[7:2];
  assign sp2_hit = byte1[7:2] == second_sp[7:2];
  assign spg_hit = byte1[7:2] == hras_pkg::GROUP_SERVICE_PT;
  assign ep1_hit = ep_byte[7:1] == first_ep[7:1];
  assign ep2_hit = ep_byte[7:1] == second_ep[7:1];
  assign epg_hit = ep_byte == hras_pkg::GROUP_ENDPOINT_ID;

  always_comb begin
    spc     = hras_pkg::SPC_SECOND;
    epf     = 1'b0;
    addr_ok = 1'b0;
    if (!addr2 && !m_tr3) begin
      addr_ok = ep1_hit || ep2_hit;
      epf     = ep1_hit;
    end else if (sp1_hit && (ep1_hit || epg_hit || (sp2_hit && ep2_hit))) begin
      spc     = hras_pkg::SPC_FIRST;
      epf     = !epg_hit;
      addr_ok = 1'b1;
    end else if (sp2_hit && (ep2_hit || epg_hit)) begin
      spc     = hras_pkg::SPC_SECOND;
      epf     = !epg_hit;
      addr_ok = 1'b1;
    end else if (spg_hit && (ep1_hit || ep2_hit || epg_hit)) begin
      spc     = hras_pkg::SPC_GROUP;
      epf     = !epg_hit;
      addr_ok = 1'b1;
    end
    if (m_tr3) begin
      addr_ok = 1'b1;
      spc     = sp1_hit ? hras_pkg::SPC_FIRST
              : (spg_hit ? hras_pkg::SPC_GROUP : hras_pkg::SPC_SECOND);
    end
  end

  // ==========================================================
  // Data to the receive queue and byte count
  // ==========================================================
  logic        need_match;
  logic        drop;
  logic        push;
  logic [11:0] cnt;
  logic        length_overflow_flag;

  assign need_match = m_auto || m_nonauto;
  assign drop = (need_match && !addr_ok) || (m_auto && is_s && cur > ctl_pos);
  assign push = i_rx_byte_valid && !i_rx_frame_end && cur >= data_pos && !drop;

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_queue_valid <= 1'b0;
      o_queue_data  <= 8'h00;
    end else begin
      o_queue_valid <= push;
      if (push)
        o_queue_data <= i_rx_byte;
    end
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cnt                  <= 12'h000;
      length_overflow_flag <= 1'b0;
    end else if (i_rx_frame_end) begin
      cnt                  <= 12'h000;
      length_overflow_flag <= 1'b0;
    end else if (push) begin
      cnt <= cnt + 12'h001;
      if (cnt == hras_pkg::COUNT_MAX)
        length_overflow_flag <= 1'b1;
    end
  end

  // ==========================================================
  // Frame end, visible status and hold
  // ==========================================================
  logic       sframe_end;
  logic       report;
  logic [7:0] ctl_view;
  logic [1:0] spc_view;
  logic       epf_view;

  assign sframe_end = i_rx_frame_end && m_auto && addr_ok && is_s;
  assign report = i_rx_frame_end && (!need_match || addr_ok) && !sframe_end;
  assign ctl_view = (mod128 && !is_u) ? {ctl2[3:1], ctl2[0], ctl1[3:1], 1'b0}
                                      : ctl1;
  assign spc_view = (addr2 && need_match) || m_tr3 ? spc : 2'h0;
  assign epf_view = (m_tr2 || m_tr3) ? 1'b0 : epf;

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      hold      <= 1'b0;
      st_status <= 8'h00;
      st_ctrl   <= 8'h00;
      st_count  <= 12'h000;
      st_length_overflow <= 1'b0;
    end else if (report && !hold) begin
      hold      <= 1'b1;
      st_status <= {cnt != 12'h000 || push, 1'b0, i_rx_crc_ok, i_rx_aborted,
                    spc_view, byte1[hras_pkg::CR_BIT], epf_view};
      st_ctrl   <= (m_tr2 || m_tr3) ? st_ctrl : ctl_view;
      st_count  <= cnt;
      st_length_overflow <= length_overflow_flag;
    end else if (ack_cmd) begin
      hold <= 1'b0;
    end
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_message_end   <= 1'b0;
      o_sframe_rx     <= 1'b0;
      o_auto_numbered <= 1'b0;
    end else begin
      o_message_end   <= report && !hold;
      o_sframe_rx     <= sframe_end;
      o_auto_numbered <= i_rx_frame_end && m_auto && addr2
                         && spc == hras_pkg::SPC_FIRST && epf
                         && ep1_hit && first_ep != hras_pkg::GROUP_ENDPOINT_ID
                         && !is_u;
    end
  end

  // ==========================================================
  // Transmitter busy flag
  // ==========================================================
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      busy_cmd <= 1'b0;
      busy_sf  <= 1'b0;
    end else begin
      if (i_tx_cmd)
        busy_cmd <= 1'b1;
      else if (i_tx_done)
        busy_cmd <= 1'b0;
      if (i_sframe_tx_start)
        busy_sf <= 1'b1;
      else if (i_sframe_tx_done)
        busy_sf <= 1'b0;
    end
  end

  // ==========================================================
  // Checks
  // ==========================================================
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);

  sequence s_frame_reported;
    report && !hold;
  endsequence
  sequence s_held_no_ack;
    hold && !ack_cmd && !(report && !hold);
  endsequence

  a_hold_on_end: assert property (s_frame_reported |=> hold && o_message_end)
    else $error("hold not set at message end");
  a_status_frozen: assert property (s_held_no_ack |=> $stable(st_status)
                                    && $stable(st_count))
    else $error("status changed while held");
  a_ack_release: assert property (hold && ack_cmd |=> !hold)
    else $error("ack did not release hold");
  a_busy_set: assert property (i_tx_cmd |=> busy_cmd [*1] ##0 (busy_cmd || busy_sf))
    else $error("busy flag not set");
  a_sframe_hidden: assert property (sframe_end |=> o_sframe_rx && !o_message_end)
    else $error("supervisory frame reported");
  a_overflow_count: assert property (push && cnt == hras_pkg::COUNT_MAX
                                     && !i_rx_frame_end |=> length_overflow_flag)
    else $error("overflow not flagged");
  a_high_read: assert property (i_psel && !i_penable && !i_pwrite
                                && idx == hras_pkg::IDX_RX_COUNT_HIGH
                                |=> o_prdata[6:5] == CHIP_VERSION
                                && o_prdata[3:0] == $past(st_count[11:8]))
    else $error("upper count read wrong");
  a_compress_i: assert property ((s_frame_reported and (mod128 && !is_u
                                 && !m_tr2 && !m_tr3))
                                 |=> st_ctrl[0] == 1'b0
                                 && st_ctrl[7:5] == $past(ctl2[3:1]))
    else $error("control field not compressed");
endmodule : hras_top

// *** tb/hras_cpu_model.sv ***
// Processor model: APB master with register access and frame pickup tasks.
// Assumes an APB slave on i_mclk; every wait on pready is bounded.
`timescale 1ns/1ps
module hras_cpu_model (
  input  wire logic        i_mclk,
  input  wire logic        i_pready,
  input  wire logic        i_pslverr,
  input  wire logic [31:0] i_prdata,
  output logic             o_psel,
  output logic             o_penable,
  output logic             o_pwrite,
  output logic [9:0]       o_paddr,
  output logic [31:0]      o_pwdata,
  output logic [3:0]       o_pstrb
);
  initial begin
    o_psel = 1'b0;
    o_penable = 1'b0;
    o_pwrite = 1'b0;
    o_paddr = 10'h000;
    o_pwdata = 32'h00000000;
    o_pstrb = 4'hF;
  end
  // ==========================================================
  // One transfer: setup, then access until pready
  // ==========================================================
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] wd,
                      output logic [7:0] rd, output logic err, output bit ok);
    ok = 1'b0;
    rd = 8'h00;
    err = 1'b0;
    @(posedge i_mclk);
    o_psel <= 1'b1;
    o_pwrite <= w;
    o_paddr <= {idx, 2'b00};
    o_pwdata <= {24'h000000, wd};
    @(posedge i_mclk);
    o_penable <= 1'b1;
    for (int n = 0; n < 64 && !ok; n++) begin
      @(posedge i_mclk);
      if (i_pready === 1'b1) begin
        rd = i_prdata[7:0];
        err = i_pslverr;
        ok = 1'b1;
      end
    end
    o_psel <= 1'b0;
    o_penable <= 1'b0;
  endtask : xfer
  // ==========================================================
  // Frame pickup: status and counts first, then acknowledge
  // ==========================================================
  task automatic take_frame(output logic [31:0] v, output bit ok);
    logic [7:0] idx[4] = '{hras_pkg::IDX_RX_STATUS, hras_pkg::IDX_RX_CTRL,
                           hras_pkg::IDX_RX_COUNT_HIGH, hras_pkg::IDX_RX_COUNT_LOW};
    logic [7:0] r;
    logic       e;
    bit         k;
    ok = 1'b1;
    foreach (idx[i]) begin
      xfer(1'b0, idx[i], 8'h00, r, e, k);
      v[31-8*i -: 8] = r;
      ok = ok & k;
    end
    xfer(1'b1, hras_pkg::IDX_COMMAND, 8'h01, r, e, k);
    ok = ok & k;
  endtask : take_frame
endmodule : hras_cpu_model

// *** tb/hdlc_rx_address_status_bench.sv ***
// Self-checking bench for the receive address recognition block.
// Assumes the processor model hras_cpu_model and a 100 MHz clock.
`timescale 1ns/1ps
module hdlc_rx_address_status_bench;
  logic        i_mclk, i_sys_rst, psel, penable, pwrite, pready, pslverr;
  logic [9:0]  paddr;
  logic [31:0] pwdata, prdata, fr;
  logic [3:0]  pstrb, tx_ev;
  logic        rx_v, rx_end, q_v, m_end, sf_rx, auto_n;
  logic [7:0]  rx_b, q_d;
  logic [7:0]  q[$];
  int          n_end, n_sf, n_an, n_mismatch, tests_run;

  hras_top #(.CHIP_VERSION(2'h2)) dut (
    .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb),
    .o_pready(pready), .o_pslverr(pslverr), .o_prdata(prdata),
    .i_rx_byte_valid(rx_v), .i_rx_byte(rx_b), .i_rx_frame_end(rx_end),
    .i_rx_crc_ok(1'b1), .i_rx_aborted(1'b0), .o_queue_valid(q_v), .o_queue_data(q_d),
    .o_message_end(m_end), .o_sframe_rx(sf_rx), .o_auto_numbered(auto_n),
    .i_tx_cmd(tx_ev[0]), .i_tx_done(tx_ev[1]), .i_sframe_tx_start(tx_ev[2]),
    .i_sframe_tx_done(tx_ev[3]));

  hras_cpu_model cpu (
    .i_mclk(i_mclk), .i_pready(pready), .i_pslverr(pslverr), .i_prdata(prdata),
    .o_psel(psel), .o_penable(penable), .o_pwrite(pwrite), .o_paddr(paddr),
    .o_pwdata(pwdata), .o_pstrb(pstrb));

  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end

  always @(posedge i_mclk) begin
    if (q_v === 1'b1) q.push_back(q_d);
    if (m_end === 1'b1) n_end++;
    if (sf_rx === 1'b1) n_sf++;
    if (auto_n === 1'b1) n_an++;
  end
  // ==========================================================
  // Shared tasks
  // ==========================================================
  task automatic end_sim;
    if (n_mismatch == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_sim

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic no_hang(input bit ok);
    if (!ok) begin
      n_mismatch++;
      end_sim();
    end
  endtask : no_hang

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] r;
    logic       e;
    bit         ok;
    cpu.xfer(1'b1, idx, d, r, e, ok);
    no_hang(ok);
  endtask : wr

  task automatic rd(input logic [7:0] idx, output logic [7:0] r, output logic e);
    bit ok;
    cpu.xfer(1'b0, idx, 8'h00, r, e, ok);
    no_hang(ok);
  endtask : rd

  task automatic take;
    bit ok;
    cpu.take_frame(fr, ok);
    no_hang(ok);
  endtask : take

  task automatic send(input logic [7:0] b[$]);
    q.delete();
    n_end = 0;
    n_sf = 0;
    n_an = 0;
    foreach (b[i]) begin
      @(posedge i_mclk);
      rx_v <= 1'b1;
      rx_b <= b[i];
    end
    @(posedge i_mclk);
    rx_v <= 1'b0;
    rx_end <= 1'b1;
    @(posedge i_mclk);
    rx_end <= 1'b0;
    repeat (3) @(posedge i_mclk);
  endtask : send

  task automatic chkq(input logic [7:0] e[$]);
    chk("queue size", 8'(e.size()), 8'(q.size()));
    foreach (e[i]) if (i < q.size()) chk("queue data", e[i], q[i]);
  endtask : chkq
  // ==========================================================
  // Scenarios
  // ==========================================================
  task automatic t_regs;
    logic [7:0] r;
    logic       e;
    rd(hras_pkg::IDX_LINK_STATUS2, r, e);
    chk("ls2 reset", 8'h00, r);
    wr(hras_pkg::IDX_LINK_STATUS2, 8'h04);
    rd(hras_pkg::IDX_LINK_STATUS2, r, e);
    chk("ls2 multiframe", 8'h04, r);
    rd(hras_pkg::IDX_FIRST_EP, r, e);
    chk("wo read", 8'h00, r);
    rd(8'h10, r, e);
    chk("unmapped err", 8'h01, {7'h00, e});
  endtask : t_regs

  task automatic t_one;
    wr(hras_pkg::IDX_MODE, 8'h01);
    wr(hras_pkg::IDX_FIRST_EP, 8'h43);
    wr(hras_pkg::IDX_SECOND_EP, 8'h85);
    send('{8'h43, 8'h13, 8'hAA, 8'h55});
    chk("msg end", 8'h01, 8'(n_end));
    chkq('{8'hAA, 8'h55});
    send('{8'h85, 8'h13, 8'h77});
    chk("held end", 8'h00, 8'(n_end));
    take;
    chk("status", 8'hA1, fr[31:24] & 8'hFD);
    chk("ctrl", 8'h13, fr[23:16]);
    chk("cnt high", 8'h40, fr[15:8]);
    chk("cnt low", 8'h02, fr[7:0]);
    send('{8'h85, 8'h13, 8'h77});
    take;
    chk("status", 8'hA0, fr[31:24] & 8'hFD);
    send('{8'h66, 8'h13, 8'h77});
    chk("miss end", 8'h00, 8'(n_end));
    chk("miss queue", 8'h00, 8'(q.size()));
  endtask : t_one

  task automatic t_two;
    logic [23:0] tab[6] = '{24'h164305, 24'h14FF04, 24'hFC8503,
                            24'hFEFF02, 24'h408501, 24'h42FF00};
    wr(hras_pkg::IDX_MODE, 8'h09);
    wr(hras_pkg::IDX_FIRST_SP, 8'h14);
    wr(hras_pkg::IDX_SECOND_SP, 8'h40);
    foreach (tab[i]) begin
      send('{tab[i][23:16], tab[i][15:8], 8'h03, 8'h5A});
      take;
      chk("status", {4'hA, tab[i][2:1], tab[i][17], tab[i][0]}, fr[31:24]);
    end
    wr(hras_pkg::IDX_SECOND_SP, 8'h14);
    send('{8'h14, 8'h85, 8'h03, 8'h5A});
    take;
    chk("equal sp", 8'hA9, fr[31:24]);
  endtask : t_two

  task automatic t_trans;
    wr(hras_pkg::IDX_MODE, 8'h03);
    send('{8'h11, 8'h22, 8'h33});
    chkq('{8'h11, 8'h22, 8'h33});
    take;
    chk("status", 8'h80, fr[31:24] & 8'hCD);
    wr(hras_pkg::IDX_MODE, 8'h04);
    send('{8'hFC, 8'h22, 8'h33});
    chkq('{8'h22, 8'h33});
    take;
    chk("status", 8'hA4, fr[31:24]);
  endtask : t_trans

  task automatic t_auto;
    wr(hras_pkg::IDX_MODE, 8'h08);
    wr(hras_pkg::IDX_SECOND_SP, 8'h42);
    wr(hras_pkg::IDX_FIRST_EP, 8'h43);
    send('{8'h16, 8'h43, 8'h0A, 8'h07, 8'hC3});
    chk("auto pulse", 8'h01, 8'(n_an));
    chkq('{8'hC3});
    take;
    chk("ctrl", 8'h7A, fr[23:16]);
    send('{8'h16, 8'h43, 8'h03, 8'h99});
    chkq('{8'h99});
    take;
    chk("ctrl", 8'h03, fr[23:16]);
    send('{8'h16, 8'h43, 8'h01, 8'h07});
    chk("s pulse", 8'h01, 8'(n_sf));
    chk("s end", 8'h00, 8'(n_end));
    wr(hras_pkg::IDX_SECOND_SP, 8'h40);
    send('{8'h16, 8'h43, 8'hB4, 8'hD2});
    take;
    chk("ctrl", 8'hB4, fr[23:16]);
    wr(hras_pkg::IDX_FIRST_EP, 8'hFF);
    send('{8'h16, 8'hFF, 8'hB4, 8'hD2});
    chk("auto off", 8'h00, 8'(n_an));
    take;
  endtask : t_auto

  task automatic t_busy;
    logic [7:0] r;
    logic       e;
    for (int k = 0; k < 4; k++) begin
      @(posedge i_mclk);
      tx_ev[k] <= 1'b1;
      @(posedge i_mclk);
      tx_ev <= 4'h0;
      rd(hras_pkg::IDX_RX_COUNT_HIGH, r, e);
      chk("busy", {7'h00, k[0] == 1'b0}, {7'h00, r[7]});
    end
  endtask : t_busy

  task automatic t_ovf;
    logic [7:0] b[$];
    wr(hras_pkg::IDX_MODE, 8'h03);
    for (int i = 0; i < 4096; i++) b.push_back(i[7:0]);
    send(b);
    take;
    chk("cnt high", 8'h50, fr[15:8]);
    chk("cnt low", 8'h00, fr[7:0]);
  endtask : t_ovf

  initial begin
    i_sys_rst = 1'b1;
    rx_v = 1'b0;
    rx_end = 1'b0;
    rx_b = 8'h00;
    tx_ev = 4'h0;
    n_mismatch = 0;
    tests_run = 0;
    repeat (8) @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    t_regs();
    t_one();
    t_two();
    t_trans();
    t_auto();
    t_busy();
    t_ovf();
    end_sim();
  end
endmodule : hdlc_rx_address_status_bench
